// ### design/tp_map.svh
// register map, field positions and reset values of the timer with prescaler
`ifndef TP_MAP_SVH
`define TP_MAP_SVH

// register indices; byte address is four times the index
`define TP_IDX_PRESCALE 10'h0D2
`define TP_IDX_COUNTER 10'h0D3
`define TP_IDX_CONTROL 10'h0D4
`define TP_IDX_OPT 10'h0D5

// control and option register field positions
`define TP_BIT_ZERO 7
`define TP_BIT_EIRQ 6
`define TP_BIT_OSEL 5
`define TP_BIT_DOUT 4
`define TP_BIT_INIT 3
`define TP_TAP_HI 2
`define TP_TAP_LO 0
`define TP_BIT_PULLUP 0

// reset values
`define TP_RST_COUNTER 8'hFF
`define TP_RST_PRESCALE 7'h7F
`define TP_RST_CONTROL 8'h00
`define TP_RST_OPT 1'b0

// internal clock divided by twelve feeds the prescaler
`define TP_ICLK_DIV 12

`endif

// ### design/tp_pkg.sv
// types shared by the timer with prescaler
package tp_pkg;

  // order follows {pin_output_select, data_out}
  typedef enum logic [1:0] {
    TP_EVENT,
    TP_GATED,
    TP_OUT_LOW,
    TP_OUT_HIGH
  } tp_mode_e;

  typedef struct packed {
    logic zero_irq_enable;
    logic pin_output_select;
    logic data_out;
    logic prescale_run_init;
    logic [2:0] tap_select;
  } tp_ctrl_s;

endpackage : tp_pkg

// ### design/tp_sync.sv
// three-stage synchroniser for the timer pin with level and rising-edge outputs
`timescale 1ns/1ps
module tp_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_in,
  output logic level,
  output logic rise
);

  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts once the second and third stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 1'b0;
      rise <= 1'b0;
    end else begin
      rise <= 1'b0;
      if (s2 == s3) begin
        level <= s3;
        rise <= s3 & ~level;
      end
    end
  end

endmodule : tp_sync

// ### design/tp_div.sv
// divider that gives a one-cycle enable every DIV clock cycles
`timescale 1ns/1ps
`include "tp_map.svh"
module tp_div #(
  parameter int DIV = `TP_ICLK_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);

  logic [7:0] cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      tick <= 1'b0;
    end else if (cnt == 8'(DIV - 1)) begin
      cnt <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 8'h01;
      tick <= 1'b0;
    end
  end

endmodule : tp_div

// ### design/tp_timer.sv
// 8-bit down-counter with 7-bit prescaler behind an APB slave
//
// Notes on behaviour
// R1: counter decrements once per selected prescaler output edge; software loads and reads it
// R2: counter decrementing to zero sets count_zero_flag
// R3: interrupt request when flag set and zero_irq_enable one; also wakes from wait
// R4: prescaler clock is internal clock over twelve or timer pin, rising edge
// R5: tap one uses prescaler input clock, tap two bit 0, four bit 1
// R6: tap select codes 000 to 111 give ratios 1 to 128
// R7: prescale_run_init low forces prescaler to 7Fh and holds counter
// R8: software may load prescaler 0 to 7Fh only while init bit is one
// R9: output select and data out pick event, gated, output low, output high
// R10: gated mode counts internal ticks only while timer pin is high
// R11: event mode decrements prescaler on each timer pin rising edge
// R12: output mode clocks from internal ticks and drives pin from latch
// R13: pin latch follows data out while flag high, holds when low
// R14: writing 00h to counter or one to control bit 7 sets flag
// R15: software clears the flag in service and before a new count
// R16: reset gives counter FFh, prescaler 7Fh, control register cleared
// R17: counter write beats a same-cycle decrement to zero; flag not set
// R18: counter and prescaler reads return their current values any time
// R19: on-chip pull-up on timer pin is a software option
// R20: prescaler register bit 7 reads zero, bits 6 to 0 the value
// R21: after zero the counter wraps to FFh and keeps counting
`timescale 1ns/1ps
`include "tp_map.svh"
module tp_timer #(
  parameter int ADDR_W = 12,
  parameter int ICLK_DIV = `TP_ICLK_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_pullup_en,
  output logic timer_irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tp_pkg::tp_ctrl_s ctrl;
  tp_pkg::tp_mode_e mode;
  logic [7:0] down_counter_reg;
  logic [6:0] prescale_value_reg;
  logic count_zero_flag;
  logic pullup_opt;
  logic pin_latch;

  logic iclk_tick;
  logic pin_level;
  logic pin_rise;
  logic ps_tick;
  logic [6:0] presc_dec;
  logic [2:0] tap_bit;
  logic tap_hit;
  logic cnt_tick;
  logic zero_hit;
  logic next_flag;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [9:0] idx;
  logic hit_prescale;
  logic hit_counter;
  logic hit_control;
  logic hit_opt;
  logic hit_any;
  logic setup;
  logic wr_en;
  logic prescale_wr;
  logic counter_wr;
  logic control_wr;
  logic opt_wr;

  assign idx = paddr[11:2];

  always_comb begin
    hit_prescale = 1'b0;
    hit_counter = 1'b0;
    hit_control = 1'b0;
    hit_opt = 1'b0;
    if (idx == `TP_IDX_PRESCALE) begin
      hit_prescale = 1'b1;
    end else if (idx == `TP_IDX_COUNTER) begin
      hit_counter = 1'b1;
    end else if (idx == `TP_IDX_CONTROL) begin
      hit_control = 1'b1;
    end else if (idx == `TP_IDX_OPT) begin
      hit_opt = 1'b1;
    end
  end

  assign hit_any = hit_prescale | hit_counter | hit_control | hit_opt;
  assign setup = psel & ~penable;
  // the slave never stalls; unmapped accesses end with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  // only the low byte lane holds register bits
  assign wr_en = psel & penable & pwrite & pstrb[0];
  assign prescale_wr = wr_en & hit_prescale;
  assign counter_wr = wr_en & hit_counter;
  assign control_wr = wr_en & hit_control;
  assign opt_wr = wr_en & hit_opt;

  // read data captured in the setup cycle, presented in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup & ~pwrite) begin
      if (hit_prescale) begin
        prdata <= {24'h00_0000, 1'b0, prescale_value_reg}; // R20 R18
      end else if (hit_counter) begin
        prdata <= {24'h00_0000, down_counter_reg}; // R18 R1
      end else if (hit_control) begin
        prdata <= {24'h00_0000, count_zero_flag, ctrl};
      end else if (hit_opt) begin
        prdata <= {31'h0000_0000, pullup_opt};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // control and option registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= tp_pkg::tp_ctrl_s'(7'(`TP_RST_CONTROL)); // R16
    end else if (control_wr) begin
      ctrl <= tp_pkg::tp_ctrl_s'(pwdata[6:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_opt <= `TP_RST_OPT;
    end else if (opt_wr) begin
      pullup_opt <= pwdata[`TP_BIT_PULLUP]; // R19
    end
  end

  assign pin_pullup_en = pullup_opt; // R19
  assign mode = tp_pkg::tp_mode_e'({ctrl.pin_output_select, ctrl.data_out}); // R9

  // ----------------------------------------------------------------
  // clock sources
  // ----------------------------------------------------------------
  tp_div #(
    .DIV(ICLK_DIV)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick(iclk_tick)
  );

  tp_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(pin_in),
    .level(pin_level),
    .rise(pin_rise)
  );

  // prescaler input clock per mode
  always_comb begin
    case (mode)
      tp_pkg::TP_EVENT: ps_tick = pin_rise; // R11 R4
      tp_pkg::TP_GATED: ps_tick = iclk_tick & pin_level; // R10
      default: ps_tick = iclk_tick; // R12 R4
    endcase
  end

  // ----------------------------------------------------------------
  // prescaler and tap
  // ----------------------------------------------------------------
  assign presc_dec = prescale_value_reg - 7'h01;
  assign tap_bit = ctrl.tap_select - 3'h1;

  // counter clock is the rising edge of the chosen prescaler bit
  always_comb begin
    if (ctrl.tap_select == 3'h0) begin
      tap_hit = 1'b1; // R5 R6
    end else begin
      tap_hit = ~prescale_value_reg[tap_bit] & presc_dec[tap_bit]; // R5 R6
    end
  end

  assign cnt_tick = ps_tick & ctrl.prescale_run_init & tap_hit; // R1 R7

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_value_reg <= `TP_RST_PRESCALE; // R16
    end else if (!ctrl.prescale_run_init) begin
      prescale_value_reg <= `TP_RST_PRESCALE; // R7
    end else if (prescale_wr) begin
      prescale_value_reg <= pwdata[6:0]; // R8
    end else if (ps_tick) begin
      prescale_value_reg <= presc_dec; // R4
    end
  end

  // ----------------------------------------------------------------
  // down-counter
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      down_counter_reg <= `TP_RST_COUNTER; // R16
    end else if (counter_wr) begin
      down_counter_reg <= pwdata[7:0]; // R1 R17
    end else if (cnt_tick) begin
      down_counter_reg <= down_counter_reg - 8'h01; // R1 R21
    end
  end

  // ----------------------------------------------------------------
  // zero flag; a hardware set wins over a software clear
  // ----------------------------------------------------------------
  assign zero_hit = cnt_tick & (down_counter_reg == 8'h01) & ~counter_wr; // R2 R17

  always_comb begin
    next_flag = count_zero_flag;
    if (control_wr & ~pwdata[`TP_BIT_ZERO]) begin
      next_flag = 1'b0;
    end
    if (zero_hit) begin
      next_flag = 1'b1; // R2
    end
    if (counter_wr & (pwdata[7:0] == 8'h00)) begin
      next_flag = 1'b1; // R14
    end
    if (control_wr & pwdata[`TP_BIT_ZERO]) begin
      next_flag = 1'b1; // R14
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_zero_flag <= 1'b0;
    end else begin
      count_zero_flag <= next_flag;
    end
  end

  assign timer_irq = count_zero_flag & ctrl.zero_irq_enable; // R3

  // ----------------------------------------------------------------
  // timer pin output
  // ----------------------------------------------------------------
  // latch follows data out while the flag is high, one clock late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_latch <= 1'b0;
    end else if (count_zero_flag) begin
      pin_latch <= ctrl.data_out; // R13
    end
  end

  assign pin_out = pin_latch; // R12
  assign pin_oe = ctrl.pin_output_select; // R9 R12

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_INIT_FORCE: assert property ( // R7
    @(posedge pclk) disable iff (!presetn)
    !ctrl.prescale_run_init |=> prescale_value_reg == 7'h7F
  ) else $error("prescaler not forced to 7Fh while stopped");

  AST_CNT_HOLD: assert property ( // R7
    @(posedge pclk) disable iff (!presetn)
    (!ctrl.prescale_run_init && !counter_wr) |=> $stable(down_counter_reg)
  ) else $error("counter moved while stopped");

  AST_DECREMENT: assert property ( // R1
    @(posedge pclk) disable iff (!presetn)
    (cnt_tick && !counter_wr) |=> down_counter_reg == $past(down_counter_reg) - 8'h01
  ) else $error("counter did not decrement by one");

  AST_WRAP: assert property ( // R21
    @(posedge pclk) disable iff (!presetn)
    (cnt_tick && !counter_wr && down_counter_reg == 8'h00) |=> down_counter_reg == 8'hFF
  ) else $error("counter did not wrap to FFh");

  AST_ZERO_SET: assert property ( // R2
    @(posedge pclk) disable iff (!presetn)
    (cnt_tick && !counter_wr && down_counter_reg == 8'h01) |=> count_zero_flag
  ) else $error("zero flag not set on reaching zero");

  AST_IRQ: assert property ( // R3
    @(posedge pclk) disable iff (!presetn)
    (zero_hit && ctrl.zero_irq_enable && !control_wr) |=> timer_irq
  ) else $error("interrupt not raised at zero");

  AST_WR_ZERO: assert property ( // R14
    @(posedge pclk) disable iff (!presetn)
    (counter_wr && pwdata[7:0] == 8'h00) |=> count_zero_flag && down_counter_reg == 8'h00
  ) else $error("writing zero to counter did not set flag");

  AST_WR_WINS: assert property ( // R17
    @(posedge pclk) disable iff (!presetn)
    (counter_wr && cnt_tick && down_counter_reg == 8'h01 && pwdata[7:0] != 8'h00
      && !count_zero_flag)
    |=> down_counter_reg == $past(pwdata[7:0]) && !count_zero_flag
  ) else $error("counter write lost to decrement");

  AST_PRESCALE_LOAD: assert property ( // R8
    @(posedge pclk) disable iff (!presetn)
    (prescale_wr && ctrl.prescale_run_init) |=> prescale_value_reg == $past(pwdata[6:0])
  ) else $error("prescaler load ignored");

  AST_PRESCALE_READ: assert property ( // R20
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_prescale) |=> prdata[31:7] == 25'h000_0000
  ) else $error("prescaler read shows bits above 6");

  AST_GATED_HOLD: assert property ( // R10
    @(posedge pclk) disable iff (!presetn)
    (mode == tp_pkg::TP_GATED && !pin_level && ctrl.prescale_run_init && !prescale_wr)
    |=> $stable(prescale_value_reg)
  ) else $error("gated prescaler moved with pin low");

  AST_EVENT_EDGE: assert property ( // R11
    @(posedge pclk) disable iff (!presetn)
    (mode == tp_pkg::TP_EVENT && pin_rise && ctrl.prescale_run_init && !prescale_wr)
    |=> prescale_value_reg == $past(prescale_value_reg) - 7'h01
  ) else $error("event edge did not decrement prescaler");

  AST_TAP_ONE: assert property ( // R6
    @(posedge pclk) disable iff (!presetn)
    (ctrl.tap_select == 3'h0 && ps_tick && ctrl.prescale_run_init) |-> cnt_tick
  ) else $error("ratio one did not clock the counter");

  AST_PIN_FOLLOW: assert property ( // R13
    @(posedge pclk) disable iff (!presetn)
    (count_zero_flag && ctrl.pin_output_select) |=> pin_out == $past(ctrl.data_out)
  ) else $error("pin latch not transparent while flag high");

  AST_PIN_HOLD: assert property ( // R13
    @(posedge pclk) disable iff (!presetn)
    !count_zero_flag |=> $stable(pin_out)
  ) else $error("pin latch changed while flag low");

endmodule : tp_timer

// ### verif/tp_pin_model.sv
// far-side model of the timer pin: external driver, pull-up and wire level
`timescale 1ns/1ps
module tp_pin_model (
  input wire logic pclk,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic pin_pullup_en,
  output logic pin_in
);
  logic drv_en = 1'b0;
  logic drv_val = 1'b0;
  logic flip = 1'b0;
  always @(posedge pclk) begin
    flip <= ~flip;
  end
  // undriven and not pulled up: a level that wanders every cycle
  assign pin_in = pin_oe ? pin_out : drv_en ? drv_val : pin_pullup_en ? 1'b1 : flip;
  task automatic drive(input logic v);
    @(posedge pclk);
    drv_en <= 1'b1;
    drv_val <= v;
  endtask : drive
  // n rising edges, each level held hold plus one cycles
  task automatic pulse(input int n, input int hold);
    repeat (n) begin
      drive(1'b1);
      repeat (hold) @(posedge pclk);
      drive(1'b0);
      repeat (hold) @(posedge pclk);
    end
  endtask : pulse
endmodule : tp_pin_model

// ### verif/timer_with_prescaler_tb.sv
// self-checking bench of the timer with prescaler over APB
`timescale 1ns/1ps
`include "tp_map.svh"
module timer_with_prescaler_tb;
  localparam int FD = 2;
  localparam logic [11:0] A_PRESCALE = {`TP_IDX_PRESCALE, 2'b00};
  localparam logic [11:0] A_COUNTER = {`TP_IDX_COUNTER, 2'b00};
  localparam logic [11:0] A_CONTROL = {`TP_IDX_CONTROL, 2'b00};
  localparam logic [11:0] A_OPT = {`TP_IDX_OPT, 2'b00};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic pin_in, pin_out, pin_oe, pin_pullup_en, timer_irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, q2;
  logic [3:0] pstrb;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  int n, v;

  tp_timer #(.ADDR_W(12), .ICLK_DIV(FD)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .timer_irq(timer_irq));
  tp_pin_model pin_u (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .pin_in(pin_in));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask : chk
  task automatic chk_rng(input string nm, input int lo, input int hi, input logic [7:0] got);
    total_checks++;
    if ($isunknown(got) || got < lo || got > hi) begin
      n_mismatch++;
      $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, got);
    end
  endtask : chk_rng
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // outputs launched by the access edge are looked at once settled
    @(negedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic err;
    apb(1'b1, a, {24'h000000, d}, r, err);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic err;
    apb(1'b0, a, 32'h00000000, r, err);
  endtask : rd

  // ----------------------------------------
  // clock, timeout, sequence
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    v = $urandom(52620);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_PRESCALE, q);
    chk("prescale_reset", 32'h0000007F, q);
    rd(A_COUNTER, q);
    chk("counter_reset", 32'h000000FF, q);
    rd(A_CONTROL, q);
    chk("control_reset", 32'h00000000, q);
    chk("irq_reset", 32'h00000000, {31'h0, timer_irq});
    wr(A_OPT, 8'h01);
    chk("pullup", 32'h00000001, {31'h0, pin_pullup_en});
    apb(1'b0, 12'h040, 32'h0, q, e);
    chk("unmapped", 32'h00000001, {31'h0, e});
    wr(A_PRESCALE, 8'h15);
    rd(A_PRESCALE, q);
    chk("prescale_stopped", 32'h0000007F, q);
    // every tap: eight counter steps from 2, through zero and the wrap
    for (int t = 0; t < 8; t++) begin
      wr(A_CONTROL, 8'h20 | 8'(t));
      wr(A_COUNTER, 8'h02);
      wr(A_CONTROL, 8'h28 | 8'(t));
      repeat (8 * (1 << t) * FD) @(posedge pclk);
      rd(A_COUNTER, q);
      chk_rng("tap_steps", 7, 10, 8'h02 - q[7:0]);
      rd(A_CONTROL, q);
      chk("zero_flag", 32'h00000001, {31'h0, q[7]});
      chk("out_drive", 32'h00000001, {31'h0, pin_oe & ~pin_out});
    end
    wr(A_CONTROL, 8'hB8);
    repeat (2) @(posedge pclk);
    chk("out_high", 32'h00000001, {31'h0, pin_out});
    wr(A_CONTROL, 8'h30);
    wr(A_CONTROL, 8'h20);
    repeat (2) @(posedge pclk);
    chk("out_hold", 32'h00000001, {31'h0, pin_out});
    wr(A_CONTROL, 8'hA0);
    repeat (2) @(posedge pclk);
    chk("out_low", 32'h00000000, {31'h0, pin_out});
    // zero flag from software and the interrupt request
    wr(A_CONTROL, 8'h40);
    chk("irq_clear", 32'h00000000, {31'h0, timer_irq});
    wr(A_COUNTER, 8'h00);
    chk("irq_counter0", 32'h00000001, {31'h0, timer_irq});
    wr(A_CONTROL, 8'h00);
    chk("irq_serviced", 32'h00000000, {31'h0, timer_irq});
    wr(A_CONTROL, 8'h80);
    rd(A_CONTROL, q);
    chk("flag_bit7", 32'h00000080, q);
    chk("irq_masked", 32'h00000000, {31'h0, timer_irq});
    // event counting from pin edges
    pin_u.drive(1'b0);
    wr(A_CONTROL, 8'h00);
    wr(A_COUNTER, 8'h10);
    wr(A_CONTROL, 8'h08);
    v = $urandom_range(8, 127);
    wr(A_PRESCALE, 8'(v));
    rd(A_PRESCALE, q);
    chk("prescale_load", 32'(v), q);
    n = $urandom_range(1, 8);
    pin_u.pulse(n, $urandom_range(4, 7));
    repeat (6) @(posedge pclk);
    rd(A_COUNTER, q);
    chk("event_counter", 32'(8'h10 - 8'(n)), q);
    rd(A_PRESCALE, q);
    chk("event_prescale", 32'(v - n), q);
    // gated counting only while the pin is high
    wr(A_CONTROL, 8'h18);
    rd(A_COUNTER, q);
    repeat (40) @(posedge pclk);
    rd(A_COUNTER, q2);
    chk("gate_low", q, q2);
    pin_u.drive(1'b1);
    repeat (40) @(posedge pclk);
    pin_u.drive(1'b0);
    repeat (8) @(posedge pclk);
    rd(A_COUNTER, q);
    chk_rng("gate_high", 18, 22, q2[7:0] - q[7:0]);
    // counter write landing on the very edge of a decrement to zero
    wr(A_CONTROL, 8'h08);
    wr(A_COUNTER, 8'h01);
    v = $urandom_range(2, 255);
    pin_u.drive(1'b1);
    // the synced rise ticks the counter on the fifth edge after the drive
    repeat (2) @(posedge pclk);
    wr(A_COUNTER, 8'(v));
    rd(A_COUNTER, q);
    chk("wr_wins", 32'(v), q);
    rd(A_CONTROL, q);
    chk("wr_wins_flag", 32'h00000000, {31'h0, q[7]});
    report_and_stop();
  end
endmodule : timer_with_prescaler_tb
